// [mpc_config_regs.sv]
// two motor configuration registers with decoded parameter outputs
// Notes on behaviour
// - dither code selects off, 5, 10, 15 percent
// - tach open-loop select gates tach output
// - tach runs at electrical speed over n+1
// - phase resistance is mantissa shifted by count
// - bemf constant is mantissa shifted by count
// - advance scaling bit picks fixed or scaled, only while a bemf ratio is valid
// - advance time is mantissa shifted by count
// - reserved bit 15 reads zero
// - config b at 0x91, resets zero
// - config a at 0x90, resets zero
//
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
module mpc_config_regs
  import mpc_pkg::*;
(
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst_n,
  // register port
  input  wire logic [7:0]    i_addr,
  input  wire logic [15:0]   i_wdata,
  input  wire logic          i_wr,
  input  wire logic          i_rd,
  output      logic [15:0]   o_rdata,
  // motor control status inputs
  input  wire logic          i_closed_loop,
  input  wire logic          i_first_open_loop,
  input  wire logic          i_elec_rev_pulse,
  input  wire logic          i_bemf_ratio_valid,
  // decoded parameters and tach output
  output      mpc_params_s   o_params,
  output      logic          o_tach_output
);

  typedef struct packed {
    mpc_state_s  regs;
    logic [3:0]  tach_cnt;
    logic        tach;
  } mpc_all_s;

  mpc_all_s     st_reg;
  mpc_all_s     st_next;
  mpc_bus_req_s req;
  logic [1:0]   dither_select;
  logic [1:0]   tach_openloop_select;
  logic [3:0]   tach_pole_divider;
  logic         tach_gate;
  logic [10:0]  phase_res;
  logic [10:0]  bemf_const;
  logic [10:0]  advance_time;

  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  assign dither_select        = st_reg.regs.cfg_a[MPC_A_DITHER_LSB +: 2];
  assign tach_openloop_select = st_reg.regs.cfg_a[MPC_A_TACHOL_LSB +: 2];
  assign tach_pole_divider    = st_reg.regs.cfg_a[MPC_A_POLE_LSB +: 4];

  // tach is allowed to toggle only in the loop phases the code names
  always_comb begin
    unique case (tach_openloop_select)
      2'h0: tach_gate = 1'b1;
      2'h1: tach_gate = i_closed_loop;
      2'h2: tach_gate = i_closed_loop | i_first_open_loop;
      // reserved code keeps tach quiet rather than guess a behaviour
      default: tach_gate = 1'b0;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    st_next.regs.rdata = 16'h0000;
    if (req.wr) begin
      if (req.addr == MPC_ADDR_CFG_A) begin
        st_next.regs.cfg_a = req.wdata & MPC_MASK_CFG_A;
      end else if (req.addr == MPC_ADDR_CFG_B) begin
        st_next.regs.cfg_b = req.wdata & MPC_MASK_CFG_B;
      end
    end
    // unmapped addresses read zero
    if (req.rd) begin
      if (req.addr == MPC_ADDR_CFG_A) begin
        st_next.regs.rdata = st_reg.regs.cfg_a;
      end else if (req.addr == MPC_ADDR_CFG_B) begin
        st_next.regs.rdata = st_reg.regs.cfg_b & MPC_MASK_CFG_B;
      end
    end
    // divide electrical revolutions by n+1, toggling on each wrap
    if (i_elec_rev_pulse && tach_gate) begin
      if (st_reg.tach_cnt >= tach_pole_divider) begin
        st_next.tach_cnt = 4'h0;
        st_next.tach     = ~st_reg.tach;
      end else begin
        st_next.tach_cnt = st_reg.tach_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_reg.regs.cfg_a <= MPC_RST_CFG_A;
      st_reg.regs.cfg_b <= MPC_RST_CFG_B;
      st_reg.regs.rdata <= 16'h0000;
      st_reg.tach_cnt   <= 4'h0;
      st_reg.tach       <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_rdata       = st_reg.regs.rdata;
  assign o_tach_output = st_reg.tach;

  // software stores resistance pre-encoded; hardware only re-expands it
  mpc_shift_param #(.MW(4), .SW(3)) u_phase_res (
    .i_mantissa (st_reg.regs.cfg_a[MPC_A_RMANT_LSB +: 4]),
    .i_shift    (st_reg.regs.cfg_a[MPC_A_RSHIFT_LSB +: 3]),
    .o_value    (phase_res)
  );

  mpc_shift_param #(.MW(4), .SW(3)) u_bemf_const (
    .i_mantissa (st_reg.regs.cfg_b[MPC_B_KMANT_LSB +: 4]),
    .i_shift    (st_reg.regs.cfg_b[MPC_B_KSHIFT_LSB +: 3]),
    .o_value    (bemf_const)
  );

  mpc_shift_param #(.MW(4), .SW(3)) u_advance_time (
    .i_mantissa (st_reg.regs.cfg_b[MPC_B_TMANT_LSB +: 4]),
    .i_shift    (st_reg.regs.cfg_b[MPC_B_TSHIFT_LSB +: 3]),
    .o_value    (advance_time)
  );

  always_comb begin
    o_params.dither_en = (dither_select != 2'h0);
    unique case (dither_select)
      2'h1: o_params.dither_pct = MPC_DITHER_PCT_1;
      2'h2: o_params.dither_pct = MPC_DITHER_PCT_2;
      2'h3: o_params.dither_pct = MPC_DITHER_PCT_3;
      default: o_params.dither_pct = 5'd0;
    endcase
    o_params.tach_openloop_select = mpc_tach_sel_e'(tach_openloop_select);
    o_params.tach_divisor    = {1'b0, tach_pole_divider} + 5'd1;
    o_params.clk_half_adjust = st_reg.regs.cfg_a[MPC_A_CLKADJ_BIT];
    o_params.phase_res       = phase_res;
    o_params.bemf_const      = bemf_const;
    // scaling applies only once a bemf/phase voltage ratio is available
    o_params.advance_scaling_select =
      st_reg.regs.cfg_b[MPC_B_ADVSEL_BIT] & i_bemf_ratio_valid;
    o_params.advance_time    = advance_time;
  end

endmodule

// [mpc_pkg.sv]
// package: register map, field layout and carriers for the motor config bank
package mpc_pkg;

  localparam int MPC_AW = 8;
  localparam int MPC_DW = 16;

  // register addresses and reset values
  localparam logic [7:0]  MPC_ADDR_CFG_A  = 8'h90;
  localparam logic [7:0]  MPC_ADDR_CFG_B  = 8'h91;
  localparam logic [15:0] MPC_RST_CFG_A   = 16'h0000;
  localparam logic [15:0] MPC_RST_CFG_B   = 16'h0000;

  // writable bits; bit 15 of config b is reserved, bit 7 of a is kept
  localparam logic [15:0] MPC_MASK_CFG_A  = 16'hffff;
  localparam logic [15:0] MPC_MASK_CFG_B  = 16'h7fff;

  // field positions
  localparam int MPC_A_DITHER_LSB = 14;
  localparam int MPC_A_TACHOL_LSB = 12;
  localparam int MPC_A_POLE_LSB   = 8;
  localparam int MPC_A_CLKADJ_BIT = 7;
  localparam int MPC_A_RSHIFT_LSB = 4;
  localparam int MPC_A_RMANT_LSB  = 0;
  localparam int MPC_B_KSHIFT_LSB = 12;
  localparam int MPC_B_KMANT_LSB  = 8;
  localparam int MPC_B_ADVSEL_BIT = 7;
  localparam int MPC_B_TSHIFT_LSB = 4;
  localparam int MPC_B_TMANT_LSB  = 0;

  // dither span in percent for each code
  localparam logic [4:0] MPC_DITHER_PCT_1 = 5'd5;
  localparam logic [4:0] MPC_DITHER_PCT_2 = 5'd10;
  localparam logic [4:0] MPC_DITHER_PCT_3 = 5'd15;

  typedef enum logic [1:0] {
    MPC_TACH_BOTH_LOOPS,
    MPC_TACH_CLOSED_ONLY,
    MPC_TACH_CLOSED_FIRST_OPEN,
    MPC_TACH_RESERVED
  } mpc_tach_sel_e;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } mpc_bus_req_s;

  typedef struct packed {
    logic [15:0] cfg_a;
    logic [15:0] cfg_b;
    logic [15:0] rdata;
  } mpc_state_s;

  // decoded parameters handed to the motor control logic
  typedef struct packed {
    logic          dither_en;
    logic [4:0]    dither_pct;
    mpc_tach_sel_e tach_openloop_select;
    logic [4:0]    tach_divisor;
    logic          clk_half_adjust;
    logic [10:0]   phase_res;
    logic [10:0]   bemf_const;
    logic          advance_scaling_select;
    logic [10:0]   advance_time;
  } mpc_params_s;

endpackage

// [mpc_shift_param.sv]
// mantissa left-shifted by a three-bit count
`timescale 1ns/100ps
module mpc_shift_param
  import mpc_pkg::*;
#(
  parameter int MW = 4,
  parameter int SW = 3
) (
  // field inputs
  input  wire logic [MW-1:0]            i_mantissa,
  input  wire logic [SW-1:0]            i_shift,
  // scaled value
  output      logic [MW+(1<<SW)-2:0]    o_value
);
  localparam int OW = MW + (1 << SW) - 1;

  assign o_value = OW'({{(OW-MW){1'b0}}, i_mantissa} << i_shift);
endmodule

// [mpc_config_props.sv]
// port assertions for the motor config bank
`timescale 1ns/100ps
module mpc_config_props
  import mpc_pkg::*;
(
  // register port and decoded outputs
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic [7:0]  i_addr,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic        i_bemf_ratio_valid,
  input wire logic [15:0] o_rdata,
  input wire mpc_params_s o_params
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // read data mirror the register, so decodes are judged against them
  sequence rd_a_s;
    $past(i_rd) && $past(i_addr) == MPC_ADDR_CFG_A;
  endsequence
  sequence rd_b_s;
    $past(i_rd) && $past(i_addr) == MPC_ADDR_CFG_B;
  endsequence
  dither_pct_a: assert property (rd_a_s |-> o_params.dither_pct ==
    5'(o_rdata[15:14]) * 5'd5) else $error("dither decode wrong");
  tach_div_a: assert property (rd_a_s |-> o_params.tach_divisor ==
    5'(o_rdata[11:8]) + 5'd1) else $error("tach divisor wrong");
  phase_res_a: assert property (rd_a_s |-> o_params.phase_res ==
    11'(o_rdata[3:0]) << o_rdata[6:4]) else $error("phase res wrong");
  bemf_const_a: assert property (rd_b_s |-> o_params.bemf_const ==
    11'(o_rdata[11:8]) << o_rdata[14:12]) else $error("bemf wrong");
  adv_time_a: assert property (rd_b_s |-> o_params.advance_time ==
    11'(o_rdata[3:0]) << o_rdata[6:4]) else $error("advance wrong");
  rsvd_bit_a: assert property (rd_b_s |-> !o_rdata[15])
    else $error("reserved bit set");
  dither_en_a: assert property (rd_a_s |-> o_params.dither_en ==
    (o_rdata[15:14] != 2'b00)) else $error("dither enable wrong");
  tach_sel_a: assert property (rd_a_s |->
    o_params.tach_openloop_select == mpc_tach_sel_e'(o_rdata[13:12]) &&
    o_params.clk_half_adjust == o_rdata[7]) else $error("tach select wrong");
  adv_scale_a: assert property (rd_b_s |->
    o_params.advance_scaling_select == (o_rdata[7] && i_bemf_ratio_valid))
    else $error("advance scaling wrong");
  reset_val_a: assert property ($rose(i_rst_n) |->
    o_params.bemf_const == 11'h0 && o_params.phase_res == 11'h0 &&
    o_params.advance_time == 11'h0 && o_params.tach_divisor == 5'd1 &&
    !o_params.dither_en)
    else $error("reset value wrong");
  field_hold_a: assert property (!i_wr |=>
    $stable(o_params.phase_res) && $stable(o_params.advance_time))
    else $error("field changed");
endmodule
bind mpc_config_regs mpc_config_props u_props (
  .i_clk              (i_clk),
  .i_rst_n            (i_rst_n),
  .i_addr             (i_addr),
  .i_wr               (i_wr),
  .i_rd               (i_rd),
  .i_bemf_ratio_valid (i_bemf_ratio_valid),
  .o_rdata            (o_rdata),
  .o_params           (o_params)
);

// [tb_top.sv]
// self-checking bench for the motor config bank
`timescale 1ns/100ps
module tb_top
  import mpc_pkg::*;
;
  logic        i_clk = '0, i_rst_n = '0, i_wr = '0, i_rd = '0, rd_d = '0;
  logic        i_closed_loop = '0, i_first_open_loop = '0, tach_d = '0;
  logic        i_elec_rev_pulse = '0, i_bemf_ratio_valid = '0, o_tach_output;
  logic [7:0]  i_addr = '0;
  logic [15:0] i_wdata = '0, o_rdata, d, sh [2] = '{16'h0, 16'h0}, expq [$];
  mpc_params_s o_params;
  int          mismatches = 0, n_compared = 0, tog = 0, n, r, s;
  always #2 i_clk = ~i_clk;
  mpc_config_regs u_dut (
    .i_clk              (i_clk),
    .i_rst_n            (i_rst_n),
    .i_addr             (i_addr),
    .i_wdata            (i_wdata),
    .i_wr               (i_wr),
    .i_rd               (i_rd),
    .o_rdata            (o_rdata),
    .i_closed_loop      (i_closed_loop),
    .i_first_open_loop  (i_first_open_loop),
    .i_elec_rev_pulse   (i_elec_rev_pulse),
    .i_bemf_ratio_valid (i_bemf_ratio_valid),
    .o_params           (o_params),
    .o_tach_output      (o_tach_output)
  );
  task automatic chk(string s, logic [15:0] e, g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  // both bus strobes are set on every call, so no signal is driven twice at once
  task automatic op(logic w, r, logic [7:0] a, logic [15:0] v, e);
    {i_wr, i_rd, i_addr, i_wdata} <= {w, r, a, v};
    i_bemf_ratio_valid <= 1'($urandom);
    if (r) expq.push_back(e);
    @(posedge i_clk);
  endtask
  task automatic complete_run;
    if (mismatches == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge i_clk) begin
    rd_d <= i_rd;
    tach_d <= o_tach_output;
    if (rd_d) chk("rdata", expq.pop_front(), o_rdata);
    if (tach_d !== o_tach_output) tog++;
  end
  initial begin
    #20000 mismatches++;
    complete_run;
  end
  initial begin
    void'($urandom(32'hc81a));
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    for (int k = 0; k < 40; k++) begin
      for (int j = 0; j < 3; j++)
        op(1'b0, 1'b1, 8'h90 + 8'(j), '0, j < 2 ? sh[j] : 16'h0);
      d = {k[1:0], 14'($urandom)}; // top bits walk every dither code
      op(1'b1, 1'b0, 8'h90 + 8'(k % 3), d, '0);
      if (k % 3 < 2) sh[k % 3] = d & (k % 3 ? 16'h7fff : 16'hffff);
    end
    n = $urandom_range(15);
    for (int c = 0; c < 5; c++) begin
      d = {2'b00, ((c == 4) ? 2'b01 : 2'(c)), 4'(n), 8'h00};
      op(1'b1, 1'b0, MPC_ADDR_CFG_A, d, '0);
      op(1'b0, 1'b0, '0, '0, '0);
      {i_closed_loop, i_first_open_loop} <= {c == 4, c != 4};
      tog = 0;
      repeat (2 * n + 2) begin
        i_elec_rev_pulse <= 1'b1;
        @(posedge i_clk);
        i_elec_rev_pulse <= 1'b0;
        @(posedge i_clk);
      end
      @(posedge i_clk); // the last toggle lands before it is counted
      chk("tach", c % 2 ? 16'h0 : 16'h2, 16'(tog));
    end
    for (int m = 0; m < 8; m++) begin
      r = $urandom_range(2047);
      s = 0;
      while ((r >> s) > 15) s++;
      // software keeps the top four bits and counts the dropped ones
      d = {9'h000, 3'(s), 4'(r >> s)};
      op(1'b1, 1'b0, MPC_ADDR_CFG_A, d, '0);
      op(1'b0, 1'b1, MPC_ADDR_CFG_A, '0, d);
      chk("phase_res", 16'(r - r % (1 << s)),
          16'(o_params.phase_res));
    end
    // two idle cycles so the last read is compared before the verdict
    repeat (2) op(1'b0, 1'b0, '0, '0, '0);
    complete_run;
  end
endmodule
